//--- rtl/ddma_pkg.sv
// constants and types of the distributed channel claim block
// assumes one 100 MHz clock and 8-bit I/O data from the host side
package ddma_pkg;

   // ==========================================
   // geometry
   localparam int NUM_CH = 8;
   localparam int REGION_BITS = 4;
   localparam int CH_BITS = 3;
   localparam logic [2:0] CASCADE_CH = 3'h4;

   // ==========================================
   // offsets inside a channel region
   localparam logic [3:0] OFF_ADDR_LO = 4'h0;
   localparam logic [3:0] OFF_ADDR_HI = 4'h1;
   localparam logic [3:0] OFF_PAGE = 4'h2;
   localparam logic [3:0] OFF_PAGE_HI = 4'h3;
   localparam logic [3:0] OFF_CNT_LO = 4'h4;
   localparam logic [3:0] OFF_CNT_HI = 4'h5;
   localparam logic [3:0] OFF_CNT_XHI = 4'h6;
   localparam logic [3:0] OFF_RSVD = 4'h7;
   localparam logic [3:0] OFF_STATUS = 4'h8;
   localparam logic [3:0] OFF_REQUEST = 4'h9;
   localparam logic [3:0] OFF_MASK_SET = 4'ha;
   localparam logic [3:0] OFF_MODE = 4'hb;
   localparam logic [3:0] OFF_BP_CLEAR = 4'hc;
   localparam logic [3:0] OFF_FULL_CLEAR = 4'hd;
   localparam logic [3:0] OFF_MASK_CLEAR = 4'he;
   localparam logic [3:0] OFF_MASK = 4'hf;

   // ==========================================
   // field positions
   localparam int SEL_MASTER_BIT = 4;
   localparam int CMD_DRQ_LOW_BIT = 6;
   localparam int CMD_DISABLE_BIT = 2;
   localparam int REQ_SET_BIT = 2;
   localparam int MASK_SET_BIT = 2;
   localparam int MASK_BIT = 0;
   localparam int STAT_PEND_LSB = 4;
   localparam int STAT_TC_LSB = 0;

   // ==========================================
   // reset values
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] CMD_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic MASK_RST = 1'b0;
   localparam logic [7:0] SHADOW_ZERO = 8'h00;

   // ==========================================
   // types
   typedef enum logic [1:0] {XFER_DEMAND, XFER_SINGLE, XFER_BLOCK, XFER_CASCADE} xfer_mode_e;
   typedef enum logic [1:0] {DIR_RSVD_LO, DIR_MEM_WRITE, DIR_MEM_READ, DIR_RSVD_HI} xfer_dir_e;

   typedef struct packed {
      xfer_mode_e sel;
      logic down;
      logic autoinit;
      xfer_dir_e dir;
      logic [1:0] unused;
   } mode_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] page;
      logic [7:0] page_hi;
      logic [15:0] count;
      logic [7:0] count_hi;
      mode_s mode;
      logic mask;
      logic sw_req;
      logic tc;
   } chan_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } io_req_s;

   typedef struct packed {
      logic done;
      logic claim;
      logic [7:0] rdata;
   } io_rsp_s;

   typedef struct packed {
      chan_s [NUM_CH-1:0] ch;
      logic [1:0][7:0] cmd;
      logic [1:0] bp;
      logic [NUM_CH-1:0] drq_meta;
      logic [NUM_CH-1:0] drq_sync;
      io_rsp_s rsp;
   } state_s;

endpackage

//--- rtl/ddma_claim.sv
// channel group claiming remapped I/O cycles in a distributed scheme
// assumes the host presents one I/O cycle per valid pulse, same clock,
// and that configuration space logic supplies base and selector
`timescale 1ns/10ps
module ddma_claim
   import ddma_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire io_req_s io_req_i,
   input wire logic [15:0] io_base_i,
   input wire logic [7:0] cfg_select_i,
   input wire logic peer_claim_i,
   input wire logic [NUM_CH-1:0] dreq_i,
   input wire logic [NUM_CH-1:0] tc_i,
   output io_rsp_s io_rsp_o,
   output mode_s [NUM_CH-1:0] mode_o,
   output logic [NUM_CH-1:0] svc_req_o
);

   // ==========================================
   // reset release
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // ==========================================
   // decode
   state_s q;
   state_s d;
   logic in_window;
   logic [2:0] ch;
   logic [3:0] off;
   logic grp;
   logic is_master;
   logic own;
   logic chan_claim;
   logic legal;
   logic claim_ok;
   logic [2:0] tgt;
   logic [NUM_CH-1:0] pend;
   logic [NUM_CH-1:0] dir_ok;

   // base is region-aligned to 128 bytes, so low 7 bits of it are ignored
   assign in_window = io_req_i.addr[15:REGION_BITS+CH_BITS]
      == io_base_i[15:REGION_BITS+CH_BITS];
   assign ch = io_req_i.addr[REGION_BITS +: CH_BITS];
   assign off = io_req_i.addr[REGION_BITS-1:0];
   assign grp = ch[2];
   assign is_master = cfg_select_i[SEL_MASTER_BIT];
   // selector bit 4 is the master flag, never a claim bit
   assign own = (ch != CASCADE_CH) && cfg_select_i[ch];
   assign chan_claim = own || (is_master
      && ((ch == CASCADE_CH) || !peer_claim_i));
   assign tgt = {grp, io_req_i.wdata[1:0]};

   always_comb begin
      legal = 1'b0;
      if (io_req_i.write) begin
         legal = (off != OFF_RSVD);
      end else begin
         case (off)
            OFF_ADDR_LO, OFF_ADDR_HI, OFF_PAGE, OFF_PAGE_HI: legal = 1'b1;
            OFF_CNT_LO, OFF_CNT_HI, OFF_CNT_XHI: legal = 1'b1;
            OFF_STATUS, OFF_MASK: legal = 1'b1;
            // write-only readback exists only as master shadows
            OFF_REQUEST, OFF_MODE, OFF_FULL_CLEAR: legal = is_master;
            default: legal = 1'b0;
         endcase
      end
   end

   assign claim_ok = io_req_i.valid && in_window && chan_claim && legal;

   // ==========================================
   // per-channel request view
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
         assign pend[gi] = (q.drq_sync[gi] ^ q.cmd[gi/4][CMD_DRQ_LOW_BIT])
            | q.ch[gi].sw_req;
         assign dir_ok[gi] = (q.ch[gi].mode.sel == XFER_CASCADE)
            || (q.ch[gi].mode.dir == DIR_MEM_WRITE)
            || (q.ch[gi].mode.dir == DIR_MEM_READ);
         assign svc_req_o[gi] = pend[gi] && !q.ch[gi].mask
            && !q.cmd[gi/4][CMD_DISABLE_BIT] && dir_ok[gi];
         assign mode_o[gi] = q.ch[gi].mode;
      end
   endgenerate

   assign io_rsp_o = q.rsp;

   // ==========================================
   // next state
   always_comb begin
      d = q;
      d.drq_meta = dreq_i;
      d.drq_sync = q.drq_meta;
      d.rsp.done = io_req_i.valid;
      d.rsp.claim = claim_ok;
      d.rsp.rdata = SHADOW_ZERO;
      if (claim_ok && io_req_i.write) begin
         case (off)
            OFF_ADDR_LO: begin
               if (q.bp[grp]) begin
                  d.ch[ch].addr[15:8] = io_req_i.wdata;
               end else begin
                  d.ch[ch].addr[7:0] = io_req_i.wdata;
               end
               d.bp[grp] = !q.bp[grp];
            end
            OFF_ADDR_HI: d.ch[ch].addr[15:8] = io_req_i.wdata;
            OFF_PAGE: d.ch[ch].page = io_req_i.wdata;
            OFF_PAGE_HI: d.ch[ch].page_hi = io_req_i.wdata;
            OFF_CNT_LO: begin
               if (q.bp[grp]) begin
                  d.ch[ch].count[15:8] = io_req_i.wdata;
               end else begin
                  d.ch[ch].count[7:0] = io_req_i.wdata;
               end
               d.bp[grp] = !q.bp[grp];
            end
            OFF_CNT_HI: d.ch[ch].count[15:8] = io_req_i.wdata;
            OFF_CNT_XHI: d.ch[ch].count_hi = io_req_i.wdata;
            OFF_STATUS: d.cmd[grp] = io_req_i.wdata;
            OFF_REQUEST: d.ch[tgt].sw_req = io_req_i.wdata[REQ_SET_BIT];
            OFF_MASK_SET: d.ch[ch].mask = io_req_i.wdata[MASK_SET_BIT];
            OFF_MODE: d.ch[tgt].mode = mode_s'(io_req_i.wdata);
            OFF_BP_CLEAR: d.bp[grp] = 1'b0;
            OFF_FULL_CLEAR: begin
               for (int i = 0; i < 4; i++) begin
                  d.ch[{grp, 2'(i)}].mode = mode_s'(MODE_RST);
                  d.ch[{grp, 2'(i)}].mask = 1'b1;
                  d.ch[{grp, 2'(i)}].sw_req = 1'b0;
                  d.ch[{grp, 2'(i)}].tc = 1'b0;
               end
               d.cmd[grp] = CMD_RST;
               d.bp[grp] = 1'b0;
            end
            OFF_MASK_CLEAR: begin
               for (int i = 0; i < 4; i++) begin
                  d.ch[{grp, 2'(i)}].mask = MASK_RST;
               end
            end
            OFF_MASK: d.ch[ch].mask = io_req_i.wdata[MASK_BIT];
            default: d.rsp.rdata = SHADOW_ZERO;
         endcase
      end else if (claim_ok) begin
         case (off)
            OFF_ADDR_LO: begin
               d.rsp.rdata = q.bp[grp] ? q.ch[ch].addr[15:8] : q.ch[ch].addr[7:0];
               d.bp[grp] = !q.bp[grp];
            end
            OFF_ADDR_HI: d.rsp.rdata = q.ch[ch].addr[15:8];
            OFF_PAGE: d.rsp.rdata = q.ch[ch].page;
            OFF_PAGE_HI: d.rsp.rdata = q.ch[ch].page_hi;
            OFF_CNT_LO: begin
               d.rsp.rdata = q.bp[grp] ? q.ch[ch].count[15:8] : q.ch[ch].count[7:0];
               d.bp[grp] = !q.bp[grp];
            end
            OFF_CNT_HI: d.rsp.rdata = q.ch[ch].count[15:8];
            OFF_CNT_XHI: d.rsp.rdata = q.ch[ch].count_hi;
            OFF_STATUS: begin
               for (int i = 0; i < 4; i++) begin
                  d.rsp.rdata[STAT_PEND_LSB+i] = pend[{grp, 2'(i)}];
                  d.rsp.rdata[STAT_TC_LSB+i] = q.ch[{grp, 2'(i)}].tc;
                  d.ch[{grp, 2'(i)}].tc = 1'b0;
               end
            end
            // shadows of write-only registers, then the read/write mask register
            OFF_REQUEST: d.rsp.rdata = {5'h00, q.ch[ch].sw_req, ch[1:0]};
            OFF_MODE: d.rsp.rdata = q.ch[ch].mode;
            OFF_MASK: d.rsp.rdata = {7'h00, q.ch[ch].mask};
            default: d.rsp.rdata = SHADOW_ZERO;
         endcase
      end
      // terminal count set wins over a status read or full clear
      for (int i = 0; i < NUM_CH; i++) begin
         if (tc_i[i]) begin
            d.ch[i].tc = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ==========================================
   // checks
   property p_outside_ignored;
      @(posedge clk_i) disable iff (!rst_n)
         io_req_i.valid && !in_window |=> q.rsp.done && !q.rsp.claim;
   endproperty
   a_outside_ignored: assert property (p_outside_ignored)
      else $error("claimed a cycle outside the remapped window");

   property p_remote_wo_read;
      @(posedge clk_i) disable iff (!rst_n)
         io_req_i.valid && !io_req_i.write && !is_master
         && (off == OFF_MODE || off == OFF_REQUEST || off == OFF_FULL_CLEAR)
         |=> !q.rsp.claim;
   endproperty
   a_remote_wo_read: assert property (p_remote_wo_read)
      else $error("remote answered a write-only read");

   property p_cascade_master;
      @(posedge clk_i) disable iff (!rst_n)
         io_req_i.valid && in_window && is_master && ch == CASCADE_CH
         && off == OFF_STATUS |=> q.rsp.claim;
   endproperty
   a_cascade_master: assert property (p_cascade_master)
      else $error("master failed to claim cascade channel");

   property p_master_default;
      @(posedge clk_i) disable iff (!rst_n)
         io_req_i.valid && in_window && is_master && !peer_claim_i
         && io_req_i.write && off != OFF_RSVD |=> q.rsp.claim;
   endproperty
   a_master_default: assert property (p_master_default)
      else $error("master left an unclaimed channel");

   property p_mask_clear;
      @(posedge clk_i) disable iff (!rst_n)
         claim_ok && io_req_i.write && off == OFF_MASK_CLEAR
         |=> !q.ch[{$past(grp), 2'h0}].mask && !q.ch[{$past(grp), 2'h3}].mask;
   endproperty
   a_mask_clear: assert property (p_mask_clear)
      else $error("mask clear left a channel masked");

   property p_full_clear;
      @(posedge clk_i) disable iff (!rst_n)
         claim_ok && io_req_i.write && off == OFF_FULL_CLEAR
         |=> q.ch[{$past(grp), 2'h1}].mask && q.cmd[$past(grp)] == CMD_RST
         && !q.bp[$past(grp)];
   endproperty
   a_full_clear: assert property (p_full_clear)
      else $error("full clear did not restore the group");

   property p_bp_clear;
      @(posedge clk_i) disable iff (!rst_n)
         claim_ok && io_req_i.write && off == OFF_BP_CLEAR |=> !q.bp[$past(grp)];
   endproperty
   a_bp_clear: assert property (p_bp_clear)
      else $error("byte pointer not cleared");

   property p_bp_toggle;
      @(posedge clk_i) disable iff (!rst_n)
         claim_ok && (off == OFF_ADDR_LO || off == OFF_CNT_LO)
         |=> q.bp[$past(grp)] != $past(q.bp[grp]);
   endproperty
   a_bp_toggle: assert property (p_bp_toggle)
      else $error("byte pointer did not alternate");

   property p_sw_request;
      @(posedge clk_i) disable iff (!rst_n)
         claim_ok && io_req_i.write && off == OFF_REQUEST
         |=> q.ch[$past(tgt)].sw_req == $past(io_req_i.wdata[REQ_SET_BIT]);
   endproperty
   a_sw_request: assert property (p_sw_request)
      else $error("software request not taken on target channel");

   property p_status_tc;
      @(posedge clk_i) disable iff (!rst_n)
         claim_ok && !io_req_i.write && off == OFF_STATUS
         |=> q.rsp.rdata[STAT_TC_LSB] == $past(q.ch[{grp, 2'h0}].tc);
   endproperty
   a_status_tc: assert property (p_status_tc)
      else $error("status terminal count bit mismatch");

   property p_disable_gates;
      @(posedge clk_i) disable iff (!rst_n)
         q.cmd[0][CMD_DISABLE_BIT] |-> svc_req_o[3:0] == 4'h0;
   endproperty
   a_disable_gates: assert property (p_disable_gates)
      else $error("disabled controller still requests service");

endmodule // ddma_claim

//--- verif/io_host_model.sv
// host side model issuing single I/O cycles to the claim block
// assumes one caller process and the same clock as the block
`timescale 1ns/10ps
module io_host_model
   import ddma_pkg::*;
(
   input wire logic clk_i,
   input wire io_rsp_s io_rsp_i,
   output io_req_s io_req_o
);
   // ==========================================
   // idle bus
   initial begin
      io_req_o = '0;
   end

   // ==========================================
   // one cycle; answer looked at while it stands
   // cycles pass as issued, no channel decoding here
   task automatic io_cycle(input logic wr, input logic [15:0] a, input logic [7:0] d,
                           output io_rsp_s r, output logic ok);
      @(negedge clk_i);
      io_req_o = '{valid: 1'b1, write: wr, addr: a, wdata: d};
      @(posedge clk_i);
      @(negedge clk_i);
      // released lines show the inverse, never a stale match
      io_req_o = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
      r = io_rsp_i;
      ok = (io_rsp_i.done === 1'b1);
   endtask
endmodule // io_host_model

//--- verif/tb_distributed_dma_channel_claim.sv
// self-checking bench of the channel claim block
// assumes the host model drives cycles; bench drives config and pins
`timescale 1ns/10ps
module tb_distributed_dma_channel_claim;
   import ddma_pkg::*;
   // ==========================================
   // signals
   localparam logic [15:0] BASE = 16'h0400;
   typedef struct packed {
      logic wr;
      logic [7:0] off;
      logic [7:0] wd;
      logic [7:0] sel;
      logic peer;
      logic claim;
      logic [7:0] rd;
   } row_s;
   logic clk;
   logic resetn;
   io_req_s io_req;
   io_rsp_s io_rsp;
   logic [15:0] io_base;
   logic [7:0] cfg_select;
   logic peer_claim;
   logic [NUM_CH-1:0] dreq;
   logic [NUM_CH-1:0] tc;
   mode_s [NUM_CH-1:0] mode_w;
   logic [NUM_CH-1:0] svc_req;
   logic [7:0] v;
   io_rsp_s r;
   int errors = 0;
   int checked = 0;
   row_s rows [12] = '{
      '{0, 8'h07, 8'h00, 8'h01, 0, 0, 8'h00},
      '{0, 8'h0a, 8'h00, 8'h01, 0, 0, 8'h00},
      '{0, 8'h09, 8'h00, 8'h01, 0, 0, 8'h00},
      '{0, 8'h0d, 8'h00, 8'h01, 0, 0, 8'h00},
      '{0, 8'h39, 8'h00, 8'h10, 0, 1, 8'h03},
      '{0, 8'h1f, 8'h00, 8'h01, 0, 0, 8'h00},
      '{0, 8'h1f, 8'h00, 8'h02, 0, 1, 8'h00},
      '{0, 8'h1f, 8'h00, 8'h10, 0, 1, 8'h00},
      '{0, 8'h1f, 8'h00, 8'h10, 1, 0, 8'h00},
      '{0, 8'h4f, 8'h00, 8'h10, 1, 1, 8'h00},
      '{0, 8'h4f, 8'h00, 8'hef, 0, 0, 8'h00},
      '{0, 8'h8f, 8'h00, 8'hff, 0, 0, 8'h00}
   };

   io_host_model u_host (.clk_i(clk), .io_rsp_i(io_rsp), .io_req_o(io_req));
   ddma_claim u_dut (.clk_i(clk), .resetn_i(resetn), .io_req_i(io_req), .io_base_i(io_base),
      .cfg_select_i(cfg_select), .peer_claim_i(peer_claim), .dreq_i(dreq), .tc_i(tc),
      .io_rsp_o(io_rsp), .mode_o(mode_w), .svc_req_o(svc_req));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========================================
   // shared tasks
   task automatic report_and_stop();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input logic w, input logic [7:0] off, input logic [7:0] d,
                      output io_rsp_s rr);
      logic ok;
      u_host.io_cycle(w, BASE + 16'(off), d, rr, ok);
      if (!ok) begin
         errors++;
         $display("CHECK FAILED %0t no answer", $time);
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [7:0] off, input logic [7:0] d);
      io_rsp_s rr;
      cyc(1'b1, off, d, rr);
   endtask
   task automatic rd(input logic [7:0] off, output logic [7:0] q);
      io_rsp_s rr;
      cyc(1'b0, off, 8'h00, rr);
      q = rr.rdata;
   endtask

   // ==========================================
   // main sequence
   initial begin
      io_base = BASE;
      cfg_select = 8'hff; // one owner, one master here
      peer_claim = 1'b0;
      dreq = 8'h00;
      tc = 8'h00;
      resetn = 1'b0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      resetn = 1'b1;
      repeat (3) @(posedge clk);
      check(svc_req, 8'h00);
      for (int i = 0; i < NUM_CH; i++) begin
         check(mode_w[i], MODE_RST);
      end
      foreach (rows[i]) begin
         cfg_select = rows[i].sel;
         peer_claim = rows[i].peer;
         cyc(rows[i].wr, rows[i].off, rows[i].wd, r);
         check({7'h00, r.claim}, {7'h00, rows[i].claim});
         check(r.rdata, rows[i].rd);
      end
      cfg_select = 8'hff;
      peer_claim = 1'b0;
      // mode target channel in the region's group comes from data, not from the region
      wr(8'h0b, 8'h76);
      check(mode_w[2], 8'h76);
      for (int m = 0; m < 4; m++) begin
         wr(8'h5b, {2'(m), 6'h05});
         check(8'(mode_w[5].sel), 8'(m));
      end
      wr(8'h09, 8'h06);
      check(svc_req, 8'h04);
      rd(8'h08, v);
      check(v, 8'h40);
      rd(8'h29, v);
      check(v, 8'h06);
      wr(8'h08, 8'h04);
      check(svc_req, 8'h00);
      wr(8'h08, 8'h00);
      check(svc_req, 8'h04);
      wr(8'h2f, 8'h01);
      check(svc_req, 8'h00);
      rd(8'h2f, v);
      check(v, 8'h01);
      wr(8'h0e, 8'h5a);
      check(svc_req, 8'h04);
      wr(8'h09, 8'h02);
      check(svc_req, 8'h00);
      // pins idle low read as pending once sense is low
      wr(8'h08, 8'h40);
      repeat (3) @(negedge clk);
      rd(8'h18, v);
      check(v, 8'hf0);
      dreq = 8'h2f;
      repeat (3) @(negedge clk);
      check(svc_req, 8'h20);
      rd(8'h58, v);
      check(v, 8'h20);
      dreq = 8'h00;
      wr(8'h08, 8'h00);
      tc = 8'h02;
      @(negedge clk);
      tc = 8'h00;
      rd(8'h08, v);
      check(v, 8'h02);
      rd(8'h08, v);
      check(v, 8'h00);
      wr(8'h0c, 8'h00);
      wr(8'h10, 8'h34);
      wr(8'h10, 8'h12);
      rd(8'h11, v);
      check(v, 8'h12);
      wr(8'h1c, 8'hff);
      rd(8'h10, v);
      check(v, 8'h34);
      rd(8'h10, v);
      check(v, 8'h12);
      wr(8'h1d, 8'h00);
      check(mode_w[2], 8'h00);
      rd(8'h3f, v);
      check(v, 8'h01);
      // second reset in mid-run
      resetn = 1'b0;
      @(negedge clk);
      check(mode_w[5], MODE_RST);
      resetn = 1'b1;
      repeat (3) @(posedge clk);
      rd(8'h2f, v);
      check(v, 8'h00);
      report_and_stop();
   end
endmodule // tb_distributed_dma_channel_claim
